/* File: core/clock_generator_select.v */
// clock generator control: four byte registers on apb, oscillator run
// controls, pin mode decode and a glitch-free fclk source sequencer.
// assumes oscillator stable flags arrive asynchronously from the analog
// macros and that the gate vector drives an external glitchless clock tree.
//
// Summary of operation
// - mode top bits pick high-speed pin function
// - mode bit 0 sets crystal frequency range
// - run bit 7 low runs crystal or clock
// - run bit 1 high starts middle oscillator
// - run bit 0 low keeps high oscillator
// - system bit 7 reports cpu clock source
// - system bit 6 requests cpu clock source
// - system bit 5 reports main clock source
// - system bit 4 chooses main clock source
// - system bit 1 reports on-chip oscillator source
// - system bit 0 selects on-chip oscillator source
// - speed bit 4 feeds timers from low oscillator
`timescale 1ns/10ps
`include "clock_generator_select_regs.vh"

module clock_generator_select (
  input wire pclk, // bus and control clock
  input wire presetn, // asynchronous reset, active low
  input wire pce, // clock enable, freezes all state when low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb write
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  input wire [3:0] pstrb, // apb byte strobes
  output wire pready, // apb ready
  output reg [31:0] prdata, // apb read data
  output reg pslverr, // apb error on unmapped address
  input wire xtal_stable, // crystal or external clock stable, async
  input wire high_osc_stable, // high-speed on-chip oscillator stable
  input wire mid_osc_stable, // middle-speed on-chip oscillator stable
  input wire sub_clk_stable, // subsystem clock stable, async
  output reg crystal_osc_run, // crystal amplifier enable
  output reg ext_clock_accept, // external clock input accepted
  output reg crystal_pin_port_mode, // both pins are plain inputs
  output reg ext_pin_clock_mode, // second pin is external clock input
  output reg crystal_high_range, // crystal above 10 MHz
  output reg mid_osc_run, // middle-speed oscillator enable
  output reg high_osc_run, // high-speed oscillator enable
  output reg timer_clock_low_osc, // timers counted from low oscillator
  output reg [3:0] fclk_gate, // one-hot fclk source gate, zero in gap
  output reg switch_busy // a source switch is under way
);

  localparam ST_IDLE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_GAP = 2'b10;

  localparam JOB_ONCHIP = 2'b00;
  localparam JOB_MAIN = 2'b01;
  localparam JOB_CPU = 2'b10;

  localparam integer DEAD_LAST_INT = `DEAD_CYCLES - 1;
  localparam [3:0] DEAD_LAST = DEAD_LAST_INT[3:0];

  reg [7:0] osc_mode_control;
  reg [7:0] osc_run_control;
  reg [7:0] sys_sel;
  reg [7:0] speed_control;
  reg cpu_clock_source_status;
  reg main_clock_source_status;
  reg onchip_osc_source_status;
  reg [3:0] sync_stage1;
  reg [3:0] sync_stage2;
  reg [1:0] state;
  reg [1:0] job;
  reg [3:0] gap_count;
  reg [1:0] next_state;
  reg [1:0] next_job;
  reg [3:0] next_gate;
  reg [7:0] read_byte;
  reg read_ok;

  wire [1:0] pin_mode;
  wire xtal_path_on;
  wire cpu_clock_source_select;
  wire main_clock_source_select;
  wire main_onchip_sel;
  wire pend_onchip;
  wire pend_main;
  wire pend_cpu;
  wire [3:0] src_ok;
  wire [1:0] onchip_src;
  wire [1:0] main_src;
  wire [1:0] live_src;
  wire [1:0] target_onchip;
  wire [1:0] target_main;
  wire [1:0] target_cpu;
  wire [1:0] job_target;
  wire job_pending;
  wire wr_en;
  wire setup;

  // which source is ready, by source code
  function src_ready;
    input [1:0] src;
    input [3:0] ok;
    begin
      src_ready = ok[src];
    end
  endfunction

  // source feeding fclk from a given set of choices
  function [1:0] fclk_source;
    input cpu_sub;
    input main_mx;
    input onchip_mid;
    begin
      if (cpu_sub) begin
        fclk_source = `SRC_SUB;
      end else if (main_mx) begin
        fclk_source = `SRC_MX;
      end else if (onchip_mid) begin
        fclk_source = `SRC_MID;
      end else begin
        fclk_source = `SRC_HIGH;
      end
    end
  endfunction

  // one-hot gate for a source code
  function [3:0] gate_of;
    input [1:0] src;
    begin
      gate_of = 4'h0;
      gate_of[src] = 1'b1;
    end
  endfunction

  assign pready = pce;
  assign setup = pce & psel & ~penable;
  assign wr_en = pce & psel & penable & pwrite & pstrb[0];

  assign pin_mode = {osc_mode_control[`EXT_CLK_MODE_BIT],
                     osc_mode_control[`OSC_PIN_SEL_BIT]};
  // oscillator path live only in crystal or external mode and not stopped
  assign xtal_path_on = ((pin_mode == `PIN_MODE_XTAL) |
                         (pin_mode == `PIN_MODE_EXT)) &
                        ~osc_run_control[`XTAL_STOP_BIT];

  assign cpu_clock_source_select = sys_sel[`CPU_SRC_SEL_BIT];
  assign main_clock_source_select = sys_sel[`MAIN_SRC_SEL_BIT];
  assign main_onchip_sel = sys_sel[`ONCHIP_SEL_BIT];

  assign pend_onchip = main_onchip_sel != onchip_osc_source_status;
  assign pend_main = main_clock_source_select != main_clock_source_status;
  assign pend_cpu = cpu_clock_source_select != cpu_clock_source_status;

  // a source counts only when running and reported stable; the subsystem clock needs only its stable flag
  assign src_ok[`SRC_HIGH] = high_osc_run & sync_stage2[0];
  assign src_ok[`SRC_MID] = mid_osc_run & sync_stage2[1];
  assign src_ok[`SRC_MX] = xtal_path_on & sync_stage2[2];
  assign src_ok[`SRC_SUB] = sync_stage2[3];

  assign onchip_src = onchip_osc_source_status ? `SRC_MID : `SRC_HIGH;
  assign main_src = main_clock_source_status ? `SRC_MX : onchip_src;
  assign live_src = fclk_source(cpu_clock_source_status,
                                main_clock_source_status,
                                onchip_osc_source_status);

  assign target_onchip = main_onchip_sel ? `SRC_MID : `SRC_HIGH;
  assign target_main = main_clock_source_select ? `SRC_MX : onchip_src;
  assign target_cpu = cpu_clock_source_select ? `SRC_SUB : main_src;

  assign job_target = (job == JOB_ONCHIP) ? target_onchip :
                      (job == JOB_MAIN) ? target_main : target_cpu;
  assign job_pending = (job == JOB_ONCHIP) ? pend_onchip :
                       (job == JOB_MAIN) ? pend_main : pend_cpu;

  // stable flags come from other clock domains
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_stage1 <= 4'h0;
      sync_stage2 <= 4'h0;
    end else if (pce) begin
      sync_stage1 <= {sub_clk_stable, xtal_stable, mid_osc_stable,
                      high_osc_stable};
      sync_stage2 <= sync_stage1;
    end
  end

  // register writes, low byte lane only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_mode_control <= `OSC_MODE_RESET;
      osc_run_control <= `OSC_RUN_RESET;
      sys_sel <= `SYS_CLK_RESET;
      speed_control <= `SPEED_RESET;
    end else if (wr_en) begin
      case (paddr)
        `OSC_MODE_ADDR: begin
          osc_mode_control <= 8'h00;
          osc_mode_control[`EXT_CLK_MODE_BIT] <=
            pwdata[`EXT_CLK_MODE_BIT];
          osc_mode_control[`OSC_PIN_SEL_BIT] <=
            pwdata[`OSC_PIN_SEL_BIT];
          osc_mode_control[`XTAL_RANGE_BIT] <= pwdata[`XTAL_RANGE_BIT];
        end
        `OSC_RUN_ADDR: begin
          osc_run_control <= 8'h00;
          osc_run_control[`RUN_FIXED_ONE_BIT] <= 1'b1;
          osc_run_control[`XTAL_STOP_BIT] <= pwdata[`XTAL_STOP_BIT];
          osc_run_control[`MID_ENABLE_BIT] <= pwdata[`MID_ENABLE_BIT];
          osc_run_control[`HIGH_STOP_BIT] <= pwdata[`HIGH_STOP_BIT];
        end
        `SYS_CLK_ADDR: begin
          sys_sel <= 8'h00;
          sys_sel[`CPU_SRC_SEL_BIT] <= pwdata[`CPU_SRC_SEL_BIT];
          sys_sel[`MAIN_SRC_SEL_BIT] <= pwdata[`MAIN_SRC_SEL_BIT];
          sys_sel[`ONCHIP_SEL_BIT] <= pwdata[`ONCHIP_SEL_BIT];
        end
        `SPEED_ADDR: begin
          speed_control <= 8'h00;
          speed_control[`TIMER_LOW_OSC_BIT] <=
            pwdata[`TIMER_LOW_OSC_BIT];
        end
        default: osc_mode_control <= osc_mode_control;
      endcase
    end
  end

  // read mux; status bits come from the sequencer, not the selects
  always @* begin
    read_byte = 8'h00;
    read_ok = 1'b1;
    case (paddr)
      `OSC_MODE_ADDR: read_byte = osc_mode_control;
      `OSC_RUN_ADDR: read_byte = osc_run_control;
      `SYS_CLK_ADDR: begin
        read_byte = sys_sel;
        read_byte[`CPU_SRC_STAT_BIT] = cpu_clock_source_status;
        read_byte[`MAIN_SRC_STAT_BIT] = main_clock_source_status;
        read_byte[`ONCHIP_STAT_BIT] = onchip_osc_source_status;
      end
      `SPEED_ADDR: read_byte = speed_control;
      default: read_ok = 1'b0;
    endcase
  end

  // read data and error captured in the setup cycle, held through access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : {24'h000000, read_byte};
      pslverr <= ~read_ok;
    end
  end

  // sequencer: one switch at a time, inner stage first
  always @* begin
    next_state = state;
    next_job = job;
    case (state)
      ST_IDLE: begin
        if (pend_onchip) begin
          next_job = JOB_ONCHIP;
          next_state = ST_WAIT;
        end else if (pend_main) begin
          next_job = JOB_MAIN;
          next_state = ST_WAIT;
        end else if (pend_cpu) begin
          next_job = JOB_CPU;
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // abandoned request or target ready to take over
        if (!job_pending) begin
          next_state = ST_IDLE;
        end else if (src_ready(job_target, src_ok)) begin
          next_state = ST_GAP;
        end
      end
      ST_GAP: begin
        if (gap_count == DEAD_LAST) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      job <= JOB_ONCHIP;
      gap_count <= 4'h0;
    end else if (pce) begin
      state <= next_state;
      job <= next_job;
      if (state == ST_GAP) begin
        gap_count <= gap_count + 4'h1;
      end else begin
        gap_count <= 4'h0;
      end
    end
  end

  // status moves only on the last gap cycle, one cycle before the new source is gated in
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clock_source_status <= 1'b0;
      main_clock_source_status <= 1'b0;
      onchip_osc_source_status <= 1'b0;
    end else if (pce && state == ST_GAP && gap_count == DEAD_LAST) begin
      case (job)
        JOB_ONCHIP: onchip_osc_source_status <= main_onchip_sel;
        JOB_MAIN: main_clock_source_status <= main_clock_source_select;
        JOB_CPU: cpu_clock_source_status <= cpu_clock_source_select;
        default: cpu_clock_source_status <= cpu_clock_source_status;
      endcase
    end
  end

  // break before make: all gates closed through the gap
  always @* begin
    if (next_state == ST_GAP || state == ST_GAP) begin
      next_gate = 4'h0;
    end else begin
      next_gate = gate_of(live_src);
    end
  end

  // oscillator controls and gate outputs, registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crystal_osc_run <= 1'b0;
      ext_clock_accept <= 1'b0;
      crystal_pin_port_mode <= 1'b1;
      ext_pin_clock_mode <= 1'b0;
      crystal_high_range <= 1'b0;
      mid_osc_run <= 1'b0;
      high_osc_run <= 1'b1;
      timer_clock_low_osc <= 1'b0;
      fclk_gate <= `GATE_RESET;
      switch_busy <= 1'b0;
    end else if (pce) begin
      crystal_osc_run <= (pin_mode == `PIN_MODE_XTAL) &
                         ~osc_run_control[`XTAL_STOP_BIT];
      ext_clock_accept <= (pin_mode == `PIN_MODE_EXT) &
                          ~osc_run_control[`XTAL_STOP_BIT];
      crystal_pin_port_mode <= (pin_mode != `PIN_MODE_XTAL) &
                               (pin_mode != `PIN_MODE_EXT);
      ext_pin_clock_mode <= pin_mode == `PIN_MODE_EXT;
      crystal_high_range <= osc_mode_control[`XTAL_RANGE_BIT];
      mid_osc_run <= osc_run_control[`MID_ENABLE_BIT];
      high_osc_run <= ~osc_run_control[`HIGH_STOP_BIT];
      timer_clock_low_osc <= speed_control[`TIMER_LOW_OSC_BIT];
      fclk_gate <= next_gate;
      // busy stays up until the last gap cycle lets the gate reopen
      switch_busy <= (next_state != ST_IDLE) | (state == ST_GAP);
    end
  end

endmodule // clock_generator_select

/* File: pkg/clock_generator_select_regs.vh */
// register map, field positions, reset values and timing of the clock
// generator control block; included by the core, defines only
`ifndef CLOCK_GENERATOR_SELECT_REGS_VH
`define CLOCK_GENERATOR_SELECT_REGS_VH

// byte addresses on the apb bus
`define OSC_MODE_ADDR 12'h000
`define OSC_RUN_ADDR 12'h004
`define SYS_CLK_ADDR 12'h008
`define SPEED_ADDR 12'h00C

// oscillator_mode_control fields
`define EXT_CLK_MODE_BIT 7
`define OSC_PIN_SEL_BIT 6
`define XTAL_RANGE_BIT 0
`define OSC_MODE_RESET 8'h00

// oscillator_run_control fields
`define XTAL_STOP_BIT 7
`define RUN_FIXED_ONE_BIT 6
`define MID_ENABLE_BIT 1
`define HIGH_STOP_BIT 0
`define OSC_RUN_RESET 8'hC0

// system_clock_select fields
`define CPU_SRC_STAT_BIT 7
`define CPU_SRC_SEL_BIT 6
`define MAIN_SRC_STAT_BIT 5
`define MAIN_SRC_SEL_BIT 4
`define ONCHIP_STAT_BIT 1
`define ONCHIP_SEL_BIT 0
`define SYS_CLK_RESET 8'h00

// operation_speed_control fields
`define TIMER_LOW_OSC_BIT 4
`define SPEED_RESET 8'h00

// pin mode encodings of the two top mode bits
`define PIN_MODE_XTAL 2'h1
`define PIN_MODE_EXT 2'h3

// clock source codes, also the index into the gate vector
`define SRC_HIGH 2'h0
`define SRC_MID 2'h1
`define SRC_MX 2'h2
`define SRC_SUB 2'h3
`define GATE_RESET 4'h1

// dead time with every clock gate closed during a switch
`define DEAD_TIME_NS 20
`define CLK_PERIOD_NS 5
`define DEAD_CYCLES ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: verification/cgs_checker_assertions.sv */
// assertion checker for the clock generator control block
// sees only the block's ports; bound in from the testbench top
`timescale 1ns/10ps
`include "clock_generator_select_regs.vh"
module cgs_checker (
  input wire pclk, // clock
  input wire presetn, // reset, active low
  input wire pce, // clock enable
  input wire psel, // apb select
  input wire penable, // apb access
  input wire pwrite, // apb write
  input wire [11:0] paddr, // apb address
  input wire [31:0] pwdata, // apb write data
  input wire [3:0] pstrb, // apb strobes
  input wire crystal_osc_run, // crystal enable
  input wire ext_clock_accept, // external clock taken
  input wire crystal_pin_port_mode, // pins are ports
  input wire ext_pin_clock_mode, // clock input pin
  input wire crystal_high_range, // crystal range
  input wire mid_osc_run, // middle oscillator on
  input wire high_osc_run, // high oscillator on
  input wire timer_clock_low_osc, // timer clock choice
  input wire [3:0] fclk_gate, // source gates
  input wire switch_busy // switch under way
);
  wire wr_done = psel && penable && pwrite && pce && pstrb[0];
  wire wr_mode = wr_done && paddr == `OSC_MODE_ADDR;
  wire wr_run = wr_done && paddr == `OSC_RUN_ADDR;
  wire wr_speed = wr_done && paddr == `SPEED_ADDR;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_range;
    wr_mode |-> ##2 crystal_high_range == $past(pwdata[0], 2);
  endproperty
  a_range: assert property (p_range) else $error("range bit wrong");
  property p_ext_pin;
    wr_mode |-> ##2 ext_pin_clock_mode == ($past(pwdata[7:6], 2) == 2'h3);
  endproperty
  a_ext_pin: assert property (p_ext_pin) else $error("clock pin wrong");
  property p_port;
    wr_mode |-> ##2 crystal_pin_port_mode == !$past(pwdata[6], 2);
  endproperty
  a_port: assert property (p_port) else $error("port mode wrong");
  property p_run_mode;
    (!crystal_osc_run || !crystal_pin_port_mode && !ext_pin_clock_mode)
      && (!ext_clock_accept || ext_pin_clock_mode && !crystal_osc_run);
  endproperty
  a_run_mode: assert property (p_run_mode) else $error("run mode wrong");
  property p_mid;
    wr_run |-> ##2 mid_osc_run == $past(pwdata[1], 2);
  endproperty
  a_mid: assert property (p_mid) else $error("middle enable wrong");
  property p_high;
    wr_run |-> ##2 high_osc_run == !$past(pwdata[0], 2);
  endproperty
  a_high: assert property (p_high) else $error("high enable wrong");
  property p_timer;
    wr_speed |-> ##2 timer_clock_low_osc == $past(pwdata[4], 2);
  endproperty
  a_timer: assert property (p_timer) else $error("timer clock wrong");
  property p_onehot;
    $onehot0(fclk_gate);
  endproperty
  a_onehot: assert property (p_onehot) else $error("gate not one-hot");
  property p_no_jump;
    fclk_gate != 4'h0 && $past(fclk_gate) != 4'h0 |-> $stable(fclk_gate);
  endproperty
  a_no_jump: assert property (p_no_jump) else $error("gate jumped");
  property p_gap;
    $fell(|fclk_gate) |-> (fclk_gate == 4'h0)[*4] ##[1:3] fclk_gate != 4'h0;
  endproperty
  a_gap: assert property (p_gap) else $error("gap length wrong");
  property p_busy;
    fclk_gate == 4'h0 |-> switch_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("gap while idle");
  c_switch: cover property ($rose(switch_busy));
  c_gap: cover property ($fell(|fclk_gate));
  c_ext: cover property (wr_mode && pwdata[7:6] == 2'h3);
endmodule // cgs_checker

/* File: verification/tb.sv */
// self-checking testbench for the clock generator control block
// drives the apb port and oscillator stable inputs directly
`timescale 1ns/10ps
`include "clock_generator_select_regs.vh"
module tb;
  reg pclk, presetn, psel, penable, pwrite;
  reg [11:0] paddr;
  reg [31:0] pwdata;
  reg [3:0] pstrb;
  reg xtal_stable, high_osc_stable, mid_osc_stable, sub_clk_stable;
  wire pce = 1'b1;
  wire pready, pslverr, crystal_osc_run, ext_clock_accept;
  wire crystal_pin_port_mode, ext_pin_clock_mode, crystal_high_range;
  wire mid_osc_run, high_osc_run, timer_clock_low_osc, switch_busy;
  wire [3:0] fclk_gate;
  wire [31:0] prdata;
  wire [12:0] outs = {crystal_osc_run, ext_clock_accept,
    crystal_pin_port_mode, ext_pin_clock_mode, crystal_high_range,
    mid_osc_run, high_osc_run, timer_clock_low_osc, switch_busy, fclk_gate};
  integer error_cnt, n_compared;
  reg [31:0] rd;
  reg err;
  clock_generator_select i_clock_generator_select (
    .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .xtal_stable(xtal_stable), .high_osc_stable(high_osc_stable),
    .mid_osc_stable(mid_osc_stable), .sub_clk_stable(sub_clk_stable),
    .crystal_osc_run(crystal_osc_run), .ext_clock_accept(ext_clock_accept),
    .crystal_pin_port_mode(crystal_pin_port_mode),
    .ext_pin_clock_mode(ext_pin_clock_mode),
    .crystal_high_range(crystal_high_range), .mid_osc_run(mid_osc_run),
    .high_osc_run(high_osc_run), .timer_clock_low_osc(timer_clock_low_osc),
    .fclk_gate(fclk_gate), .switch_busy(switch_busy));
  task tally_and_finish;
    if (error_cnt == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string what, input [31:0] exp, input [31:0] got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
    integer i;
    reg done;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    done = 1'b0;
    for (i = 0; i < 20 && !done; i = i + 1) begin
      @(posedge pclk);
      done = (pready === 1'b1);
    end
    if (!done) begin
      error_cnt = error_cnt + 1;
      tally_and_finish;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask
  task rdc(input string what, input [11:0] a, input [31:0] exp);
    apb(1'b0, a, 32'h0, 4'hF);
    chk(what, exp, rd);
  endtask
  task settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task wait_idle;
    integer i;
    repeat (3) @(posedge pclk);
    #1;
    for (i = 0; i < 200 && switch_busy !== 1'b0; i = i + 1) begin
      @(posedge pclk);
      #1;
    end
    if (switch_busy !== 1'b0) begin
      error_cnt = error_cnt + 1;
      tally_and_finish;
    end
  endtask
  task step(input [7:0] sel, input [7:0] st, input [3:0] g);
    wr(`SYS_CLK_ADDR, {24'h0, sel});
    wait_idle;
    rdc("clock status", `SYS_CLK_ADDR, {24'h0, st});
    chk("clock gate", {28'h0, g}, {28'h0, fclk_gate});
  endtask
  task t_reset;
    #1;
    chk("reset outputs", 32'h441, {19'h0, outs});
    rdc("mode reset", `OSC_MODE_ADDR, 32'h00);
    rdc("run reset", `OSC_RUN_ADDR, 32'hC0);
    rdc("system reset", `SYS_CLK_ADDR, 32'h00);
    rdc("speed reset", `SPEED_ADDR, 32'h00);
  endtask
  task t_mode;
    integer m, s;
    reg [7:0] md;
    reg [4:0] ex;
    for (m = 0; m < 4; m = m + 1) begin
      for (s = 0; s < 2; s = s + 1) begin
        md = {m[1:0], 5'h00, m[0]};
        wr(`OSC_RUN_ADDR, {24'h0, s[0], 7'h40});
        wr(`OSC_MODE_ADDR, {24'h0, md});
        settle;
        ex = {m == 1 && s == 0, m == 3 && s == 0, !m[0], m == 3, m[0]};
        chk("pin mode", {27'h0, ex}, {27'h0, outs[12:8]});
        rdc("mode register", `OSC_MODE_ADDR, {24'h0, md});
      end
    end
  endtask
  task t_run;
    integer v;
    for (v = 0; v < 4; v = v + 1) begin
      wr(`OSC_RUN_ADDR, {24'h0, 6'h20, v[1:0]});
      settle;
      chk("osc enables", {30'h0, v[1], !v[0]}, {30'h0, outs[7:6]});
      rdc("run register", `OSC_RUN_ADDR, {24'h0, 6'h30, v[1:0]});
    end
    wr(`OSC_RUN_ADDR, 32'h80);
  endtask
  task t_speed;
    wr(`SPEED_ADDR, 32'hFFFFFFFF);
    settle;
    chk("timer clock", 32'h1, {31'h0, timer_clock_low_osc});
    rdc("speed register", `SPEED_ADDR, 32'h10);
    apb(1'b1, `SPEED_ADDR, 32'h0, 4'hE);
    settle;
    chk("masked write", 32'h1, {31'h0, timer_clock_low_osc});
    wr(`SPEED_ADDR, 32'h0);
    settle;
    chk("timer clock", 32'h0, {31'h0, timer_clock_low_osc});
    apb(1'b0, 12'h010, 32'h0, 4'hF);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
  endtask
  task t_switch;
    wr(`SYS_CLK_ADDR, 32'h01);
    repeat (10) @(posedge pclk);
    rdc("status lag", `SYS_CLK_ADDR, 32'h01);
    #1;
    chk("gate held", 32'h1, {28'h0, fclk_gate});
    chk("busy", 32'h1, {31'h0, switch_busy});
    step(8'h00, 8'h00, 4'h1);
    @(posedge pclk);
    mid_osc_stable <= 1'b1;
    wr(`OSC_RUN_ADDR, 32'h02);
    step(8'h01, 8'h03, 4'h2);
    step(8'h11, 8'h33, 4'h4);
    step(8'h51, 8'hF3, 4'h8);
    step(8'h11, 8'h33, 4'h4);
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    xtal_stable = 1'b1;
    high_osc_stable = 1'b1;
    mid_osc_stable = 1'b0;
    sub_clk_stable = 1'b1;
    error_cnt = 0;
    n_compared = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_mode;
    t_run;
    t_speed;
    t_switch;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    tally_and_finish;
  end
endmodule // tb
bind clock_generator_select cgs_checker i_cgs_checker (
  .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .crystal_osc_run(crystal_osc_run),
  .ext_clock_accept(ext_clock_accept),
  .crystal_pin_port_mode(crystal_pin_port_mode),
  .ext_pin_clock_mode(ext_pin_clock_mode),
  .crystal_high_range(crystal_high_range), .mid_osc_run(mid_osc_run),
  .high_osc_run(high_osc_run), .timer_clock_low_osc(timer_clock_low_osc),
  .fclk_gate(fclk_gate), .switch_busy(switch_busy));
